// ### hw/icm_interval_counter.sv
// One interval counter channel with six counting modes behind an APB slave
`timescale 1ns/1ps
module icm_interval_counter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cnt_clk,
  input wire logic gate_in,
  output logic cnt_out
);
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic cclk_prev_r;
  logic gate_prev_r;
  logic trig_ff_r;
  logic trig_s_r;
  logic gate_s_r;
  icm_pkg::icm_mode_t mode_r;
  logic bcd_r;
  logic [1:0] rw_r;
  logic [15:0] cr_r;
  logic [15:0] ce_r;
  logic out_r;
  logic null_r;
  logic pend_r;
  logic armed_r;
  logic hi_next_r;
  logic hold_r;
  logic run_r;
  logic done_r;
  logic apb_done;
  logic ctrl_wr;
  logic cnt_wr;
  logic wr_any;
  logic rise;
  logic fall;
  logic addr_ok;
  logic [1:0] m3_sub;
  logic [2:0] mode_raw;
  logic [7:0] status_byte;

  // Subtract k from a binary or four-digit BCD count, wrapping
  function automatic logic [15:0] icm_sub(input logic [15:0] v, input logic [1:0] k,
                                          input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b0;
    for (int j = 0; j < 3; j++) begin
      if (j < int'(k)) begin
        if (bcd) begin
          borrow = 1'b1;
          for (int i = 0; i < 4; i++) begin
            if (borrow) begin
              if (r[i*4 +: 4] == 4'h0) begin
                r[i*4 +: 4] = 4'h9;
              end else begin
                r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                borrow = 1'b0;
              end
            end
          end
        end else begin
          r = r - 16'h0001;
        end
      end
    end
    return r;
  endfunction

  assign rise = cnt_clk & ~cclk_prev_r;
  assign fall = ~cnt_clk & cclk_prev_r;

  // Write lands only at the edge where pready is seen high
  assign apb_done = psel & penable & pready_r;
  assign ctrl_wr = apb_done & pwrite & (paddr == icm_pkg::OFF_CTRL);
  assign cnt_wr = apb_done & pwrite & (paddr == icm_pkg::OFF_COUNT);
  assign wr_any = ctrl_wr | cnt_wr;
  assign addr_ok = (paddr == icm_pkg::OFF_CTRL) | (paddr == icm_pkg::OFF_COUNT) |
                   (paddr == icm_pkg::OFF_STATUS) | (paddr == icm_pkg::OFF_VALUE);
  // Codes 6 and 7 alias modes 2 and 3
  assign mode_raw = pwdata[icm_pkg::CTRL_MODE_LSB +: 3];
  assign status_byte = {out_r, null_r, rw_r, mode_r, bcd_r};
  // Odd counts take one off when high, three when low
  assign m3_sub = ce_r[0] ? (out_r ? 2'h1 : 2'h3) : 2'h2;

  // One wait state, then a single ready cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= ~addr_ok;
      prdata_r <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          icm_pkg::OFF_CTRL: prdata_r <= {26'h0, rw_r, mode_r, bcd_r};
          icm_pkg::OFF_STATUS: prdata_r <= {24'h0, status_byte};
          icm_pkg::OFF_VALUE: prdata_r <= {16'h0, ce_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign cnt_out = out_r;

  // Gate edge capture and sampling on counter clock rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cclk_prev_r <= 1'b0;
      gate_prev_r <= 1'b0;
      trig_ff_r <= 1'b0;
      trig_s_r <= 1'b0;
      gate_s_r <= 1'b0;
    end else begin
      cclk_prev_r <= cnt_clk;
      gate_prev_r <= gate_in;
      if (rise) begin
        trig_s_r <= trig_ff_r;
        gate_s_r <= gate_in;
      end
      // A new edge in the sampling cycle survives the clear
      if (gate_in && !gate_prev_r) begin
        trig_ff_r <= 1'b1;
      end else if (rise) begin
        trig_ff_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= icm_pkg::ICM_M0;
      bcd_r <= 1'b0;
      rw_r <= icm_pkg::RW_RST;
      cr_r <= icm_pkg::CR_RST;
      ce_r <= icm_pkg::CE_RST;
      out_r <= 1'b0;
      null_r <= 1'b1;
      pend_r <= 1'b0;
      armed_r <= 1'b0;
      hi_next_r <= 1'b0;
      hold_r <= 1'b0;
      run_r <= 1'b0;
      done_r <= 1'b1;
    end else if (ctrl_wr) begin
      // Mode write resets control and sets initial output
      mode_r <= icm_pkg::icm_mode_t'(mode_raw[1] ? {1'b0, mode_raw[1:0]} : mode_raw);
      bcd_r <= pwdata[icm_pkg::CTRL_BCD_BIT];
      rw_r <= (pwdata[icm_pkg::CTRL_RW_LSB +: 2] == 2'h0) ? icm_pkg::RW_RST :
              pwdata[icm_pkg::CTRL_RW_LSB +: 2];
      out_r <= (mode_raw != 3'h0);
      null_r <= 1'b1;
      pend_r <= 1'b0;
      armed_r <= 1'b0;
      hi_next_r <= 1'b0;
      hold_r <= 1'b0;
      run_r <= 1'b0;
      done_r <= 1'b1;
    end else if (cnt_wr) begin
      if (rw_r == icm_pkg::RW_BOTH && !hi_next_r) begin
        cr_r[7:0] <= pwdata[7:0];
        hi_next_r <= 1'b1;
        // First byte halts mode 0 and drops output
        if (mode_r == icm_pkg::ICM_M0) begin
          hold_r <= 1'b1;
          out_r <= 1'b0;
        end
      end else begin
        unique case (rw_r)
          icm_pkg::RW_LSB: cr_r <= {8'h00, pwdata[7:0]};
          icm_pkg::RW_MSB: cr_r <= {pwdata[7:0], 8'h00};
          default: cr_r <= {pwdata[7:0], cr_r[7:0]};
        endcase
        hi_next_r <= 1'b0;
        pend_r <= 1'b1;
        null_r <= 1'b1;
        // Held until a trigger in mode 1
        armed_r <= 1'b1;
        hold_r <= 1'b0;
        // New count in mode 0 drops the output
        if (mode_r == icm_pkg::ICM_M0) begin
          out_r <= 1'b0;
        end
      end
    end else begin
      // All loads and decrements on the falling edge
      if (fall) begin
        unique case (mode_r)
          icm_pkg::ICM_M0: begin
            if (pend_r && !hold_r) begin
              ce_r <= cr_r;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              run_r <= 1'b1;
            end else if (run_r && gate_s_r && !hold_r) begin
              ce_r <= icm_sub(ce_r, 2'h1, bcd_r);
              if (ce_r == 16'h0001) begin
                out_r <= 1'b1;
              end
            end
          end
          icm_pkg::ICM_M1: begin
            // Each trigger restarts with the held count
            if (trig_s_r && armed_r) begin
              ce_r <= cr_r;
              out_r <= 1'b0;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              run_r <= 1'b1;
            end else if (run_r) begin
              // Wraps and runs on after zero
              ce_r <= icm_sub(ce_r, 2'h1, bcd_r);
              if (ce_r == 16'h0001) begin
                out_r <= 1'b1;
              end
            end
          end
          icm_pkg::ICM_M2: begin
            // First load from software, or trigger reload
            if ((!run_r && pend_r) || (trig_s_r && armed_r)) begin
              ce_r <= cr_r;
              out_r <= 1'b1;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              run_r <= 1'b1;
            end else if (run_r && gate_s_r) begin
              // Low for the pulse at count one, then reload
              if (ce_r == 16'h0002) begin
                ce_r <= 16'h0001;
                out_r <= 1'b0;
              end else if (ce_r == 16'h0001) begin
                // Pending count enters at period end
                ce_r <= cr_r;
                out_r <= 1'b1;
                pend_r <= 1'b0;
                null_r <= 1'b0;
              end else begin
                ce_r <= icm_sub(ce_r, 2'h1, bcd_r);
              end
            end
          end
          icm_pkg::ICM_M3: begin
            // Trigger loads at once, else at half-cycle end
            if ((!run_r && pend_r) || (trig_s_r && armed_r)) begin
              ce_r <= cr_r;
              out_r <= 1'b1;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              run_r <= 1'b1;
            end else if (run_r && gate_s_r) begin
              // Even counts step by two, toggle at expiry
              // Odd counts step one or three first
              if (ce_r == {14'h0, m3_sub}) begin
                ce_r <= cr_r;
                out_r <= ~out_r;
                pend_r <= 1'b0;
                null_r <= 1'b0;
              end else begin
                ce_r <= icm_sub(ce_r, m3_sub, bcd_r);
              end
            end
          end
          icm_pkg::ICM_M4: begin
            // Strobe lasts one pulse whatever the gate
            if (!out_r) begin
              out_r <= 1'b1;
            end
            if (pend_r) begin
              ce_r <= cr_r;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              run_r <= 1'b1;
              done_r <= 1'b0;
            end else if (run_r && gate_s_r) begin
              ce_r <= icm_sub(ce_r, 2'h1, bcd_r);
              if (ce_r == 16'h0001 && !done_r) begin
                out_r <= 1'b0;
                done_r <= 1'b1;
              end
            end
          end
          default: begin
            if (!out_r) begin
              out_r <= 1'b1;
            end
            // Written count waits for a trigger
            if (trig_s_r && armed_r) begin
              ce_r <= cr_r;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              run_r <= 1'b1;
              done_r <= 1'b0;
            end else if (run_r) begin
              ce_r <= icm_sub(ce_r, 2'h1, bcd_r);
              if (ce_r == 16'h0001 && !done_r) begin
                out_r <= 1'b0;
                done_r <= 1'b1;
              end
            end
          end
        endcase
      end
      // In modes 2 and 3 gate low forces output high without a counter clock
      if ((mode_r == icm_pkg::ICM_M2 || mode_r == icm_pkg::ICM_M3) && !gate_in) begin
        out_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  mode_init_a: assert property (ctrl_wr |=>
    (out_r == (mode_r != icm_pkg::ICM_M0)) && null_r)
    else $error("mode write did not set initial output");
  m0_write_low_a: assert property ((cnt_wr && mode_r == icm_pkg::ICM_M0) |=> !out_r)
    else $error("mode 0 count write left output high");
  m0_load_a: assert property ((fall && !wr_any && mode_r == icm_pkg::ICM_M0 &&
    pend_r && !hold_r) |=> ce_r == $past(cr_r))
    else $error("mode 0 load pulse did not load held count");
  m0_wrap_a: assert property ((fall && !wr_any && mode_r == icm_pkg::ICM_M0 && run_r &&
    gate_s_r && !hold_r && !pend_r && !bcd_r && ce_r == 16'h0000) |=> ce_r == 16'hffff)
    else $error("binary counter did not wrap");
  trig_capture_a: assert property ((gate_in && !gate_prev_r) |=> trig_ff_r)
    else $error("gate rising edge not captured");
  m1_trig_low_a: assert property ((fall && !wr_any && mode_r == icm_pkg::ICM_M1 &&
    trig_s_r && armed_r) |=> !out_r && ce_r == $past(cr_r))
    else $error("mode 1 trigger did not start one-shot");
  m2_gate_high_a: assert property ((!wr_any && mode_r == icm_pkg::ICM_M2 && !gate_in)
    |=> out_r)
    else $error("mode 2 gate low did not force output high");
  m3_gate_high_a: assert property ((!wr_any && mode_r == icm_pkg::ICM_M3 && !gate_in &&
    !out_r) |=> out_r)
    else $error("mode 3 gate low did not force output high");
  m4_strobe_end_a: assert property ((fall && !wr_any && mode_r == icm_pkg::ICM_M4 &&
    !out_r) |=> out_r)
    else $error("mode 4 strobe longer than one pulse");
  ce_on_fall_a: assert property ($changed(ce_r) |-> $past(fall))
    else $error("count changed away from a falling edge");
endmodule

// ### hw/icm_pkg.sv
// Constants shared by the interval counter mode engine
package icm_pkg;
  localparam int CLK_PERIOD_NS = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_VALUE = 8'h0c;

  // Control register fields
  localparam int CTRL_BCD_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_RW_LSB = 4;

  // Byte access formats
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;

  // Reset values
  localparam logic [15:0] CE_RST = 16'h0000;
  localparam logic [15:0] CR_RST = 16'h0000;
  localparam logic [1:0] RW_RST = 2'h1;

  typedef enum logic [2:0] {
    ICM_M0 = 3'h0,
    ICM_M1 = 3'h1,
    ICM_M2 = 3'h2,
    ICM_M3 = 3'h3,
    ICM_M4 = 3'h4,
    ICM_M5 = 3'h5
  } icm_mode_t;
endpackage

// ### bench/icm_far_end.sv
// Counter clock source standing at the far side of the counter
`timescale 1ns/1ps
module icm_far_end (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [7:0] n_req,
  output logic cnt_clk,
  output logic busy
);
  logic [7:0] left_r;
  logic [2:0] ph_r;
  // Rise then fall pulses
  // Three clk per level; clock stands low between bursts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_clk <= 1'b0;
      busy <= 1'b0;
      left_r <= 8'h00;
      ph_r <= 3'h0;
    end else if (start) begin
      busy <= 1'b1;
      left_r <= n_req;
      ph_r <= 3'h0;
    end else if (busy) begin
      if (left_r == 8'h00) begin
        busy <= 1'b0;
      end else begin
        cnt_clk <= (ph_r < 3'h3);
        ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
        if (ph_r == 3'h5) begin
          left_r <= left_r - 8'h01;
        end
      end
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking bench for the interval counter mode engine
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %s exp %h got %h", nm, exp, got); end end
module tb;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, cnt_clk, gate_in, cnt_out;
  logic start, busy, err;
  logic [7:0] paddr, n_req;
  logic [31:0] pwdata, prdata, rd;
  int errors, n_checks;
  icm_interval_counter dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_clk(cnt_clk), .gate_in(gate_in), .cnt_out(cnt_out));
  icm_far_end far_u (.clk(clk), .sys_rst(sys_rst), .start(start), .n_req(n_req),
    .cnt_clk(cnt_clk), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer taken at the very edge that sees pready high
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask
  task automatic cw(input logic [31:0] d);
    apb(1'b1, icm_pkg::OFF_CTRL, d);
  endtask
  task automatic cnt(input logic [31:0] d);
    apb(1'b1, icm_pkg::OFF_COUNT, d);
  endtask
  task automatic rd_is(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", exp, rd)
  endtask
  task automatic out_is(input logic exp);
    repeat (3) @(negedge clk);
    `CHK("cnt_out", exp, cnt_out)
  endtask
  task automatic set_gate(input logic v);
    @(posedge clk);
    gate_in <= v;
    repeat (2) @(posedge clk);
  endtask
  task automatic trig();
    set_gate(1'b0);
    set_gate(1'b1);
  endtask
  // Waits for the far side to finish its burst, bounded
  task automatic pulse(input logic [7:0] n);
    int k;
    k = 0;
    @(posedge clk);
    n_req <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 3000);
    if (busy !== 1'b0) begin
      errors++;
      final_report();
    end
    repeat (3) @(negedge clk);
  endtask
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start = 1'b0;
    n_req = 8'h00;
    gate_in = 1'b1;
    errors = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    out_is(1'b0);
    rd_is(icm_pkg::OFF_CTRL, 32'h10);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pslverr", 1'b1, err)
    cw(32'h10);
    out_is(1'b0);
    cnt(32'h3);
    pulse(8'h03);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    rd_is(icm_pkg::OFF_STATUS, 32'h90);
    set_gate(1'b0);
    cnt(32'h2);
    out_is(1'b0);
    pulse(8'h05);
    out_is(1'b0);
    rd_is(icm_pkg::OFF_VALUE, 32'h2);
    set_gate(1'b1);
    pulse(8'h01);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    cw(32'h30);
    cnt(32'h5);
    cnt(32'h0);
    pulse(8'h06);
    out_is(1'b1);
    pulse(8'h01);
    rd_is(icm_pkg::OFF_VALUE, 32'hffff);
    cnt(32'h7);
    out_is(1'b0);
    pulse(8'h03);
    rd_is(icm_pkg::OFF_VALUE, 32'hffff);
    cw(32'h18);
    out_is(1'b1);
    cnt(32'h2);
    pulse(8'h02);
    out_is(1'b1);
    pulse(8'h01);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    cw(32'h14);
    cnt(32'h3);
    pulse(8'h02);
    out_is(1'b1);
    pulse(8'h01);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    pulse(8'h02);
    out_is(1'b0);
    set_gate(1'b0);
    out_is(1'b1);
    cw(32'h12);
    cnt(32'h2);
    pulse(8'h02);
    out_is(1'b1);
    trig();
    pulse(8'h01);
    out_is(1'b0);
    trig();
    pulse(8'h02);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    cw(32'h1a);
    cnt(32'h2);
    pulse(8'h02);
    out_is(1'b1);
    trig();
    pulse(8'h02);
    out_is(1'b1);
    pulse(8'h01);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    cw(32'h16);
    cnt(32'h4);
    pulse(8'h02);
    out_is(1'b1);
    pulse(8'h01);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    pulse(8'h02);
    set_gate(1'b0);
    out_is(1'b1);
    set_gate(1'b1);
    cw(32'h16);
    cnt(32'h5);
    pulse(8'h03);
    out_is(1'b1);
    pulse(8'h02);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    // Code 6 reads back as mode 2
    cw(32'h1c);
    rd_is(icm_pkg::OFF_CTRL, 32'h14);
    cw(32'h11);
    cnt(32'h1);
    pulse(8'h03);
    out_is(1'b1);
    rd_is(icm_pkg::OFF_VALUE, 32'h9999);
    cw(32'h21);
    cnt(32'h1);
    pulse(8'h02);
    rd_is(icm_pkg::OFF_VALUE, 32'h99);
    cw(32'h38);
    cnt(32'h5);
    cnt(32'h0);
    pulse(8'h03);
    cnt(32'h4);
    pulse(8'h01);
    rd_is(icm_pkg::OFF_VALUE, 32'h2);
    cnt(32'h0);
    pulse(8'h01);
    rd_is(icm_pkg::OFF_VALUE, 32'h4);
    pulse(8'h04);
    out_is(1'b0);
    cw(32'h12);
    cnt(32'h3);
    trig();
    pulse(8'h01);
    cnt(32'h6);
    pulse(8'h02);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    trig();
    pulse(8'h06);
    out_is(1'b0);
    pulse(8'h01);
    out_is(1'b1);
    cw(32'h1a);
    cnt(32'h3);
    trig();
    pulse(8'h02);
    cnt(32'h5);
    pulse(8'h02);
    out_is(1'b0);
    trig();
    pulse(8'h05);
    out_is(1'b1);
    pulse(8'h01);
    out_is(1'b0);
    final_report();
  end
endmodule
